//--- hw/gps_bus_if.sv
`timescale 1ns/10ps
interface gps_bus_if;
  import gps_pkg::*;
  // Wired-OR of both parties, 1 means the line is asserted
  logic [LN_W-1:0] h_o;
  logic [LN_W-1:0] h_oe;
  logic [LN_W-1:0] d_o;
  logic [LN_W-1:0] d_oe;
  logic [LN_W-1:0] line;
  logic atn;
  logic ren;
  logic ifc;
  logic srq_o;
  logic srq_oe;
  logic srq;

  assign line = (h_o & h_oe) | (d_o & d_oe);
  assign srq = srq_o & srq_oe;

  modport dev (input line, atn, ren, ifc, output d_o, d_oe, srq_o, srq_oe);
  modport host (input line, srq, output h_o, h_oe, atn, ren, ifc);
endinterface

//--- hw/gps_dev.sv
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
// Contract
// (R1) Talk or listen only
// (R2) Full handshakes, SRQ, RL and DC
// (R3) Talker, poll reply, talk-only; listen untalks
// (R4) Listener; talk address unlistens
// (R5) Terminator, EOI, address 1-32; CRLF/on/12
// (R6) REN enters remote
// (R7) IFC aborts bus activity
// (R8) Commands under ATN; LLO locks panel
// (R9) DCL clears interface to idle
// (R10) Addressed commands need listen address
// (R11) SDC clears only when listen addressed
// (R12) GTL while addressed returns to local
// (R13) SPE: status byte when talked; SPD ends
// (R14) Fixed status byte layout
// (R15) Enabled set bit drives SRQ
// (R16) Serial poll clears report bits
// (R17) Enable mask set by command
// (R18) SRQ only with mask bit 6 set
// (R19) Status query reads without clearing
// (R20) Bit 5 set by any event register bit
// (R21) Host frames common command text
// (R22) Event register query reads then clears
// (R23) SRQ released once no enabled bit set
module gps_dev
  import gps_pkg::*;
(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  gps_bus_if.dev bus, // Instrument bus, device end
  input wire logic cfg_we, // Settings write strobe
  input wire logic [2:0] cfg_term, // Terminator setting
  input wire logic cfg_eoi, // EOI on last byte enable
  input wire logic [5:0] cfg_addr, // Bus address, 1 to 32
  input wire logic talk_only, // Talk without being addressed
  input wire logic [7:0] stat_evt, // Status report set pulses
  input wire logic [7:0] esr_evt, // Event register set pulses
  input wire logic sre_we, // Enable mask write strobe
  input wire logic [7:0] sre_wdata, // Enable mask value
  output logic [7:0] sre_rdata, // Enable mask readback
  input wire logic stb_rd, // Status byte query strobe
  output logic [7:0] stb_rdata, // Status byte query result
  input wire logic esr_rd, // Event register query strobe
  output logic [7:0] esr_rdata, // Event register query result
  input wire logic tx_valid, // Outgoing byte offered
  input wire logic [7:0] tx_data, // Outgoing byte
  input wire logic tx_last, // Last byte of a message
  output logic tx_ready, // Outgoing byte taken
  output logic rx_valid, // Received data byte pulse
  output logic [7:0] rx_data, // Received data byte
  output logic rx_end, // Received byte carried EOI
  output logic remote, // Remote mode
  output logic panel_lock, // Front panel locked out
  output logic dev_clear, // Device clear pulse
  output logic talker, // Talk addressed
  output logic listener, // Listen addressed
  output logic srq_active // Service request pending
);
  // ==========================================================
  // Pin synchronisers
  logic [LN_W+2:0] s1_q;
  logic [LN_W+2:0] s2_q;
  logic [LN_W-1:0] ln;
  logic atn, ren, ifc, dav, nrfd, ndac, eoi;
  logic [7:0] dio;

  // Two stages before any logic looks at a bus line
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= {bus.ifc, bus.ren, bus.atn, bus.line};
      s2_q <= s1_q;
    end
  end

  // Line views
  assign ln = s2_q[LN_W-1:0];
  assign atn = s2_q[LN_W];
  assign ren = s2_q[LN_W+1];
  assign ifc = s2_q[LN_W+2];
  assign dav = ln[LN_DAV];
  assign nrfd = ln[LN_NRFD];
  assign ndac = ln[LN_NDAC];
  assign eoi = ln[LN_EOI];
  assign dio = ln[LN_DIO +: 8];

  // ==========================================================
  // Settings
  gps_term_e term_q;
  logic eoi_en_q;
  logic [5:0] addr_q;
  logic [4:0] my5;

  // Out-of-range addresses keep the old one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      term_q <= RST_TERM;
      eoi_en_q <= RST_EOI;
      addr_q <= RST_ADDR;
    end
    else if (cfg_we && cfg_addr >= ADDR_MIN && cfg_addr <= ADDR_MAX) // R5
    begin
      term_q <= gps_term_e'(cfg_term);
      eoi_en_q <= cfg_eoi;
      addr_q <= cfg_addr;
    end
  end
  assign my5 = addr_q[4:0]; // Address 32 shares code 0 on the wire

  // ==========================================================
  // Acceptor handshake and command decode
  logic acc_q, acc_on, take, is_cmd, mla, mta, ota, dclr_now, clr;
  logic lstn_q, tlk_q, spe_q, rem_q, llo_q, ren_d_q, dclr_q;
  logic [7:0] cmd;

  assign acc_on = atn | lstn_q; // R2
  assign take = acc_on & ~acc_q & dav;
  assign cmd = {1'b0, dio[6:0]};
  assign is_cmd = take & atn; // R8
  assign mla = is_cmd && cmd == {GRP_LISTEN, my5}; // R10
  assign mta = is_cmd && cmd == {GRP_TALK, my5} && cmd != MC_UNT;
  assign ota = is_cmd && cmd[7:5] == GRP_TALK && !mta;
  assign dclr_now = is_cmd && (cmd == MC_DCL || (cmd == MC_SDC && lstn_q)); // R9 R11
  assign clr = ifc | dclr_now;

  // Hold NRFD from acceptance until DAV drops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      acc_q <= 1'b0;
    else if (!acc_on || ifc)
      acc_q <= 1'b0;
    else if (take)
      acc_q <= 1'b1; // R2
    else if (acc_q && !dav)
      acc_q <= 1'b0;
  end

  // Talk and listen addressing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lstn_q <= 1'b0;
      tlk_q <= 1'b0;
    end
    else if (ifc)
    begin
      lstn_q <= 1'b0; // R7
      tlk_q <= 1'b0;
    end
    else if (mla)
    begin
      lstn_q <= 1'b1;
      tlk_q <= 1'b0; // R3
    end
    else if (mta)
    begin
      tlk_q <= 1'b1;
      lstn_q <= 1'b0; // R4
    end
    else
    begin
      if (is_cmd && cmd == MC_UNL)
        lstn_q <= 1'b0;
      if (ota)
        tlk_q <= 1'b0;
    end
  end

  // Serial poll mode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      spe_q <= 1'b0;
    else if (ifc)
      spe_q <= 1'b0; // R7
    else if (is_cmd && cmd == MC_SPE)
      spe_q <= 1'b1; // R13
    else if (is_cmd && cmd == MC_SPD)
      spe_q <= 1'b0; // R13
  end

  // Remote and lockout follow REN; both fall when REN is released
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rem_q <= 1'b0;
      llo_q <= 1'b0;
      ren_d_q <= 1'b0;
    end
    else
    begin
      ren_d_q <= ren;
      if (!ren)
      begin
        rem_q <= 1'b0;
        llo_q <= 1'b0;
      end
      else
      begin
        if (!ren_d_q)
          rem_q <= 1'b1; // R6
        else if (is_cmd && cmd == MC_GTL && lstn_q)
          rem_q <= 1'b0; // R12
        if (is_cmd && cmd == MC_LLO)
          llo_q <= 1'b1; // R8
      end
    end
  end

  // Received data and clear pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_end <= 1'b0;
      dclr_q <= 1'b0;
    end
    else
    begin
      rx_valid <= take & ~atn & lstn_q;
      dclr_q <= dclr_now; // R9
      if (take && !atn && lstn_q)
      begin
        rx_data <= dio;
        rx_end <= eoi;
      end
    end
  end

  // ==========================================================
  // Status byte, enable mask and event register
  logic [7:0] stb_q, sre_q, esr_q, stb_set, stb_view;
  logic rqs, srq_req, poll_clr;

  assign rqs = |(stb_q & sre_q & ~RQS_MASK); // R17
  assign srq_req = sre_q[SB_RQS] & rqs; // R15 R18 R23
  assign stb_view = {stb_q[7], srq_req, stb_q[5:0]}; // R14
  assign stb_set = (stat_evt & ~(RQS_MASK | ESB_MASK)) // R14
    | ((|(esr_evt & ESR_USED)) ? ESB_MASK : 8'h00); // R20

  // Sticky reports; set wins over clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stb_q <= 8'h00;
      esr_q <= 8'h00;
      sre_q <= RST_SRE;
      stb_rdata <= 8'h00;
      esr_rdata <= 8'h00;
    end
    else
    begin
      stb_q <= (poll_clr ? 8'h00 : stb_q) | stb_set; // R16
      esr_q <= (esr_rd ? 8'h00 : esr_q) | (esr_evt & ESR_USED); // R22
      if (sre_we)
        sre_q <= sre_wdata; // R17
      if (stb_rd)
        stb_rdata <= stb_view; // R19
      if (esr_rd)
        esr_rdata <= esr_q; // R22
    end
  end

  // ==========================================================
  // Source handshake
  gps_src_e st_q;
  logic [7:0] byte_q;
  logic eoi_q, have_q, poll_q, poll_sent_q, tpos_q, talking, idle_free, poll_load;
  logic [1:0] pend_q;
  logic [$clog2(SETTLE_CYC+1)-1:0] cnt_q;

  assign talking = (tlk_q | talk_only) & ~atn; // R3
  assign idle_free = st_q == SRC_IDLE && talking && !have_q && !clr;
  assign poll_load = idle_free && spe_q && tlk_q && !poll_sent_q; // R13
  assign tx_ready = idle_free && !spe_q && pend_q == 2'd0;
  assign poll_clr = st_q == SRC_DAV && talking && !ndac && poll_q; // R16

  // One status byte per poll; ATN rearms it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      poll_sent_q <= 1'b0;
    else if (atn || !spe_q)
      poll_sent_q <= 1'b0;
    else if (poll_load)
      poll_sent_q <= 1'b1;
  end

  // ATN pauses a byte; a clear drops it and its terminator
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= SRC_IDLE;
      byte_q <= 8'h00;
      eoi_q <= 1'b0;
      have_q <= 1'b0;
      poll_q <= 1'b0;
      pend_q <= 2'd0;
      tpos_q <= 1'b0;
      cnt_q <= '0;
    end
    else if (clr)
    begin
      st_q <= SRC_IDLE; // R7 R9
      have_q <= 1'b0;
      pend_q <= 2'd0;
    end
    else
    begin
      case (st_q)
        SRC_IDLE:
        begin
          cnt_q <= '0;
          if (talking && have_q)
            st_q <= SRC_SETTLE;
          else if (poll_load)
          begin
            byte_q <= stb_view; // R13
            eoi_q <= 1'b0;
            poll_q <= 1'b1;
            have_q <= 1'b1;
            st_q <= SRC_SETTLE;
          end
          else if (idle_free && !spe_q && pend_q != 2'd0)
          begin
            byte_q <= term_byte(term_q, tpos_q); // R5
            eoi_q <= eoi_en_q && pend_q == 2'd1;
            pend_q <= pend_q - 2'd1;
            tpos_q <= 1'b1;
            poll_q <= 1'b0;
            have_q <= 1'b1;
            st_q <= SRC_SETTLE;
          end
          else if (tx_ready && tx_valid)
          begin
            byte_q <= tx_data;
            eoi_q <= eoi_en_q && tx_last && term_len(term_q) == 2'd0; // R5
            pend_q <= tx_last ? term_len(term_q) : 2'd0;
            tpos_q <= 1'b0;
            poll_q <= 1'b0;
            have_q <= 1'b1;
            st_q <= SRC_SETTLE;
          end
        end
        SRC_SETTLE:
          if (!talking)
            st_q <= SRC_IDLE;
          else if (cnt_q == ($clog2(SETTLE_CYC+1))'(SETTLE_CYC - 1))
            st_q <= SRC_RFD;
          else
            cnt_q <= cnt_q + 1'b1;
        SRC_RFD:
          if (!talking)
            st_q <= SRC_IDLE;
          else if (!nrfd)
            st_q <= SRC_DAV; // R2
        SRC_DAV:
          if (!talking)
            st_q <= SRC_IDLE;
          else if (!ndac)
          begin
            st_q <= SRC_IDLE;
            have_q <= 1'b0;
          end
        default: st_q <= SRC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Pin drive
  logic drv;
  assign drv = st_q != SRC_IDLE && talking;
  always_comb
  begin
    bus.d_o = '1;
    bus.d_o[LN_DIO +: 8] = byte_q;
    bus.d_oe = '0;
    bus.d_oe[LN_DIO +: 8] = {8{drv}}; // R1
    bus.d_oe[LN_EOI] = drv & eoi_q;
    bus.d_oe[LN_DAV] = drv && st_q == SRC_DAV;
    bus.d_oe[LN_NRFD] = acc_on & acc_q;
    bus.d_oe[LN_NDAC] = acc_on & ~acc_q;
  end
  assign bus.srq_o = 1'b1;
  assign bus.srq_oe = srq_req; // R15

  assign sre_rdata = sre_q;
  assign remote = rem_q;
  assign panel_lock = llo_q;
  assign dev_clear = dclr_q;
  assign talker = tlk_q;
  assign listener = lstn_q;
  assign srq_active = srq_req;
endmodule

//--- hw/gps_host.sv
`timescale 1ns/10ps
module gps_host
  import gps_pkg::*;
(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // AHB-Lite slave select
  input wire logic [31:0] haddr, // AHB-Lite address
  input wire logic [1:0] htrans, // AHB-Lite transfer type
  input wire logic hwrite, // AHB-Lite write
  input wire logic [2:0] hsize, // AHB-Lite size, word only
  input wire logic [31:0] hwdata, // AHB-Lite write data
  input wire logic hready, // AHB-Lite bus ready
  output logic hreadyout, // Always ready, no wait states
  output logic [31:0] hrdata, // AHB-Lite read data
  output logic hresp, // Always OKAY
  gps_bus_if.host bus // Instrument bus, controller end
);
  // ==========================================================
  // Pin synchronisers
  logic [LN_W:0] s1_q;
  logic [LN_W:0] s2_q;
  logic dav, nrfd, ndac, srq;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= {bus.srq, bus.line};
      s2_q <= s1_q;
    end
  end
  assign dav = s2_q[LN_DAV];
  assign nrfd = s2_q[LN_NRFD];
  assign ndac = s2_q[LN_NDAC];
  assign srq = s2_q[LN_W];

  // ==========================================================
  // AHB-Lite slave
  logic wr_q, start;
  logic [7:0] ad_q;
  gps_host_e st_q;
  logic [7:0] byte_q, rd_q;
  logic rd_eoi_q, ren_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // Busy drops writes; poll busy first
  assign start = wr_q && ad_q == REG_CMD && st_q == H_IDLE;

  // Address phase capture, read data for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      ad_q <= 8'h00;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      wr_q <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1])
        ad_q <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite && haddr[7:0] == REG_STAT)
        hrdata <= {16'h0000, rd_q, 4'h0, ren_q, rd_eoi_q, srq, st_q != H_IDLE};
      else
        hrdata <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Controller sequencer
  logic atn_q, ifc_q, eoi_q;
  logic [$clog2(IFC_CYC+1)-1:0] cnt_q;
  gps_op_e op;
  assign op = gps_op_e'(hwdata[CMD_OP_LSB +: 3]);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= H_IDLE;
      byte_q <= 8'h00;
      rd_q <= 8'h00;
      rd_eoi_q <= 1'b0;
      atn_q <= 1'b0;
      ren_q <= 1'b0;
      ifc_q <= 1'b0;
      eoi_q <= 1'b0;
      cnt_q <= '0;
    end
    else
    begin
      case (st_q)
        H_IDLE:
        begin
          cnt_q <= '0;
          if (start)
          begin
            byte_q <= hwdata[7:0];
            eoi_q <= op == OP_DATA_END;
            case (op)
              OP_CMD:
              begin
                atn_q <= 1'b1; // R8
                st_q <= H_SETTLE;
              end
              OP_DATA, OP_DATA_END:
              begin
                atn_q <= 1'b0;
                st_q <= H_SETTLE;
              end
              OP_READ:
              begin
                atn_q <= 1'b0;
                st_q <= H_LSN;
              end
              OP_REN_ON: ren_q <= 1'b1;
              OP_REN_OFF: ren_q <= 1'b0;
              OP_IFC:
              begin
                ifc_q <= 1'b1;
                atn_q <= 1'b0;
                st_q <= H_IFC;
              end
              default: st_q <= H_IDLE;
            endcase
          end
        end
        H_SETTLE:
          if (cnt_q == ($clog2(IFC_CYC+1))'(SETTLE_CYC - 1))
            st_q <= H_RFD;
          else
            cnt_q <= cnt_q + 1'b1;
        H_RFD:
          if (!nrfd)
            st_q <= H_DAV;
        H_DAV:
          if (!ndac)
            st_q <= H_IDLE;
        H_LSN:
          if (dav)
          begin
            rd_q <= s2_q[LN_DIO +: 8];
            rd_eoi_q <= s2_q[LN_EOI];
            st_q <= H_TAKE;
          end
        H_TAKE:
          if (!dav)
            st_q <= H_IDLE;
        H_IFC:
          if (cnt_q == ($clog2(IFC_CYC+1))'(IFC_CYC - 1))
          begin
            ifc_q <= 1'b0;
            st_q <= H_IDLE;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Pin drive; idle host holds the talker off with NRFD
  logic src, lsn;
  assign src = st_q == H_SETTLE || st_q == H_RFD || st_q == H_DAV;
  assign lsn = !src && st_q != H_IFC;
  always_comb
  begin
    bus.h_o = '1;
    bus.h_o[LN_DIO +: 8] = byte_q;
    bus.h_oe = '0;
    bus.h_oe[LN_DIO +: 8] = {8{src}};
    bus.h_oe[LN_EOI] = src & eoi_q;
    bus.h_oe[LN_DAV] = st_q == H_DAV;
    bus.h_oe[LN_NRFD] = lsn && st_q != H_LSN;
    bus.h_oe[LN_NDAC] = lsn && st_q != H_TAKE;
  end
  assign bus.atn = atn_q;
  assign bus.ren = ren_q;
  assign bus.ifc = ifc_q;
endmodule

//--- hw/gps_pkg.sv
package gps_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 40;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int IFC_NS = 100000;
  localparam int IFC_CYC = (IFC_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // Line positions (1 = asserted)
  localparam int LN_NDAC = 0;
  localparam int LN_NRFD = 1;
  localparam int LN_DAV = 2;
  localparam int LN_EOI = 3;
  localparam int LN_DIO = 4;
  localparam int LN_W = 12;

  // ==========================================================
  // Bus control command bytes
  localparam logic [7:0] MC_GTL = 8'h01;
  localparam logic [7:0] MC_SDC = 8'h04;
  localparam logic [7:0] MC_LLO = 8'h11;
  localparam logic [7:0] MC_DCL = 8'h14;
  localparam logic [7:0] MC_SPE = 8'h18;
  localparam logic [7:0] MC_SPD = 8'h19;
  localparam logic [7:0] MC_UNL = 8'h3F;
  localparam logic [7:0] MC_UNT = 8'h5F;
  localparam logic [2:0] GRP_LISTEN = 3'h1;
  localparam logic [2:0] GRP_TALK = 3'h2;

  // ==========================================================
  // Settings and status
  typedef enum logic [2:0] {
    TERM_CRLF = 3'b000,
    TERM_LFCR = 3'b001,
    TERM_CR = 3'b010,
    TERM_LF = 3'b011,
    TERM_NONE = 3'b100
  } gps_term_e;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [5:0] ADDR_MIN = 6'h01;
  localparam logic [5:0] ADDR_MAX = 6'h20;
  localparam logic [5:0] RST_ADDR = 6'h0C;
  localparam logic RST_EOI = 1'b1;
  localparam gps_term_e RST_TERM = TERM_CRLF;
  localparam logic [7:0] RST_SRE = 8'h00;
  localparam int SB_RQS = 6;
  localparam logic [7:0] RQS_MASK = 8'h40;
  localparam logic [7:0] ESB_MASK = 8'h20;
  localparam logic [7:0] ESR_USED = 8'hBD;

  // ==========================================================
  // Controller registers on AHB-Lite
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CMD_OP_LSB = 8;
  typedef enum logic [2:0] {
    OP_CMD = 3'b000,
    OP_DATA = 3'b001,
    OP_DATA_END = 3'b010,
    OP_READ = 3'b011,
    OP_REN_ON = 3'b100,
    OP_REN_OFF = 3'b101,
    OP_IFC = 3'b110
  } gps_op_e;

  // ==========================================================
  // State machines
  typedef enum logic [1:0] {
    SRC_IDLE = 2'b00,
    SRC_SETTLE = 2'b01,
    SRC_RFD = 2'b10,
    SRC_DAV = 2'b11
  } gps_src_e;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SETTLE = 3'b001,
    H_RFD = 3'b010,
    H_DAV = 3'b011,
    H_LSN = 3'b100,
    H_TAKE = 3'b101,
    H_IFC = 3'b110
  } gps_host_e;

  // Number of terminator bytes for a setting
  function automatic logic [1:0] term_len(input gps_term_e sel);
    case (sel)
      TERM_CRLF, TERM_LFCR: term_len = 2'd2;
      TERM_CR, TERM_LF: term_len = 2'd1;
      default: term_len = 2'd0;
    endcase
  endfunction

  // Terminator byte at a position
  function automatic logic [7:0] term_byte(input gps_term_e sel, input logic pos);
    case (sel)
      TERM_CRLF: term_byte = pos ? CH_LF : CH_CR;
      TERM_LFCR: term_byte = pos ? CH_CR : CH_LF;
      TERM_CR: term_byte = CH_CR;
      default: term_byte = CH_LF;
    endcase
  endfunction
endpackage

//--- tb/gps_sva.sv
`timescale 1ns/10ps
module gps_sva
  import gps_pkg::*;
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic [LN_W-1:0] line, // Resolved lines
  input wire logic [LN_W-1:0] d_o, // Device values
  input wire logic [LN_W-1:0] d_oe, // Device enables
  input wire logic atn, // Attention
  input wire logic ifc, // Interface clear
  input wire logic srq // Service request
);
  // ==========================================================
  // Byte handshake steps, seen on the resolved lines and on the device drive
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic [7:0] dio = line[LN_DIO+7:LN_DIO];
  sequence dav_up;
    $rose(line[LN_DAV]);
  endsequence
  sequence dav_down;
    $fell(line[LN_DAV]);
  endsequence
  a_dav_hold: assert property (dav_down |-> !$past(line[LN_NDAC]))
    else $error("DAV dropped before NDAC released");
  a_dav_after_rfd: assert property (dav_up |-> !$past(line[LN_NRFD]))
    else $error("DAV raised while NRFD asserted");
  a_dio_stable: assert property (line[LN_DAV] && $past(line[LN_DAV]) |-> $stable(dio))
    else $error("DIO moved under DAV");
  a_dio_settle: assert property (dav_up |-> $past(dio, 40) == dio)
    else $error("DIO not settled before DAV");
  a_cmd_accept: assert property (dav_up ##0 atn |-> ##[1:6] line[LN_NRFD] && !line[LN_NDAC])
    else $error("Command byte not accepted");
  a_src_release: assert property ($fell(d_o[LN_DAV] & d_oe[LN_DAV])
    |-> (d_o[11:4] & d_oe[11:4]) == 8'h00)
    else $error("DIO kept after DAV release");
  // Clear must drop any byte the device is sourcing
  a_ifc_abort: assert property ($rose(ifc) |-> ##[1:8] !(d_o[LN_DAV] && d_oe[LN_DAV]))
    else $error("Source not aborted by IFC");
  a_reset_idle: assert property ($rose(hresetn) |-> d_oe == '0 && !srq)
    else $error("Device drives lines after reset");
endmodule

//--- tb/tb_gpib_talker_listener_status.sv
`timescale 1ns/10ps
`define CHK(e, a, t) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", t, e, a); end end
module tb_gpib_talker_listener_status;
  import gps_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, cfg_we = 0, rd_v = 0, dc_seen = 0;
  logic tx_valid = 0, tx_last = 0, sre_we = 0, stb_rd = 0, esr_rd = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_d, r;
  logic [7:0] stat_evt = 0, esr_evt = 0, sre_wdata = 0, tx_data = 0, stb_rdata, esr_rdata;
  logic [7:0] rx_data, b;
  logic hreadyout, hresp, tx_ready, rx_valid, rx_end, remote, panel_lock, dev_clear;
  logic talker, listener, srq_active;
  logic [9:0] q[$], e;
  int n_errors = 0, n_checks = 0;
  // ==========================================================
  // Clock, the two ends and the wire checker
  always #20 hclk = ~hclk;
  gps_bus_if gps_bus_if_inst ();
  gps_host gps_host_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .bus(gps_bus_if_inst));
  gps_dev gps_dev_inst (.hclk, .hresetn, .bus(gps_bus_if_inst), .cfg_we, .cfg_term(3'h0),
    .cfg_eoi(1'b1), .cfg_addr(6'h0C), .talk_only(1'b0), .stat_evt, .esr_evt, .sre_we,
    .sre_wdata, .sre_rdata(), .stb_rd, .stb_rdata, .esr_rd, .esr_rdata, .tx_valid, .tx_data,
    .tx_last, .tx_ready, .rx_valid, .rx_data, .rx_end, .remote, .panel_lock, .dev_clear,
    .talker, .listener, .srq_active);
  gps_sva gps_sva_inst (.hclk, .hresetn, .line(gps_bus_if_inst.line), .d_o(gps_bus_if_inst.d_o),
    .d_oe(gps_bus_if_inst.d_oe), .atn(gps_bus_if_inst.atn), .ifc(gps_bus_if_inst.ifc),
    .srq(gps_bus_if_inst.srq));
  // ==========================================================
  // Result watcher; note bit 9 masks EOI
  always @(posedge hclk)
  begin
    if (dev_clear === 1'b1) dc_seen <= 1'b1;
    if (tx_valid && tx_ready === 1'b1) tx_valid <= 1'b0;
    if (rx_valid === 1'b1)
    begin
      e = q.pop_front();
      `CHK(e[8:0], {rx_end, rx_data}, "rx byte")
    end
    if (rd_v === 1'b1)
    begin
      e = q.pop_front();
      `CHK(e[8:0] | {e[9], 8'h00}, {rd_d[2] | e[9], rd_d[15:8]}, "read byte")
    end
  end
  task test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Single word transfer, bounded
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    r = hrdata;
    if (n >= 50)
    begin
      n_errors++;
      test_done();
    end
  endtask
  // Controller order, then wait for idle
  task automatic op(input logic [2:0] o, input logic [7:0] d);
    int n;
    ahb(1'b1, REG_CMD, {21'h0, o, d});
    n = 0;
    do begin ahb(1'b0, REG_STAT, 32'h0); n++; end while (r[0] !== 1'b0 && n < 2000);
    if (n >= 2000)
    begin
      n_errors++;
      test_done();
    end
  endtask
  task automatic rd(input logic [9:0] x);
    q.push_back(x);
    op(OP_READ, 8'h00);
    ahb(1'b0, REG_STAT, 32'h0);
    rd_d <= r;
    rd_v <= 1'b1;
    @(posedge hclk);
    rd_v <= 1'b0;
  endtask
  // ==========================================================
  // Main sequence; no starred command text sent
  initial
  begin
    void'($urandom(92073));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk) cfg_we <= 1'b1;
    @(posedge hclk) cfg_we <= 1'b0;
    op(OP_CMD, 8'h2C);
    `CHK(1'b1, listener, "listener")
    b = $urandom;
    q.push_back({2'b00, b});
    op(OP_DATA, b);
    b = $urandom;
    q.push_back({2'b01, b});
    op(OP_DATA_END, b);
    op(OP_REN_ON, 8'h00);
    op(OP_CMD, MC_LLO);
    repeat (4) @(posedge hclk);
    `CHK(2'b11, {remote, panel_lock}, "remote lock")
    op(OP_CMD, MC_GTL);
    `CHK(1'b0, remote, "local")
    op(OP_CMD, 8'h4C);
    `CHK(2'b10, {talker, listener}, "talker")
    b = $urandom;
    tx_data <= b;
    tx_last <= 1'b1;
    tx_valid <= 1'b1;
    rd({2'b00, b});
    `CHK(1'b0, tx_valid, "tx taken")
    rd({2'b00, CH_CR});
    rd({2'b01, CH_LF});
    sre_wdata <= 8'h41;
    sre_we <= 1'b1;
    stat_evt <= 8'h01;
    stb_rd <= 1'b1;
    @(posedge hclk) sre_we <= 1'b0;
    stat_evt <= 8'h00;
    @(posedge hclk) stb_rd <= 1'b0;
    repeat (2) @(posedge hclk);
    `CHK(8'h41, stb_rdata, "status query")
    `CHK(1'b1, gps_bus_if_inst.srq, "srq set")
    op(OP_CMD, MC_SPE);
    rd({2'b10, 8'h41});
    repeat (4) @(posedge hclk);
    `CHK(1'b0, gps_bus_if_inst.srq, "srq release")
    op(OP_CMD, MC_SPD);
    sre_wdata <= 8'h01;
    sre_we <= 1'b1;
    stat_evt <= 8'h04;
    esr_evt <= 8'h01;
    @(posedge hclk) sre_we <= 1'b0;
    stat_evt <= 8'h00;
    esr_evt <= 8'h00;
    repeat (3) @(posedge hclk);
    `CHK(1'b0, gps_bus_if_inst.srq, "srq masked")
    for (int i = 0; i < 2; i++)
    begin
      esr_rd <= 1'b1;
      stb_rd <= 1'b1;
      @(posedge hclk) esr_rd <= 1'b0;
      stb_rd <= 1'b0;
      repeat (2) @(posedge hclk);
      `CHK(i ? 8'h00 : 8'h01, esr_rdata, "event query")
      `CHK(8'h04, stb_rdata & 8'h04, "settled bit")
      `CHK(1'b1, stb_rdata[5], "summary bit")
    end
    op(OP_CMD, MC_DCL);
    `CHK(1'b1, dc_seen, "device clear")
    dc_seen <= 1'b0;
    op(OP_CMD, MC_UNL);
    op(OP_CMD, MC_SDC);
    `CHK(1'b0, dc_seen, "unaddressed clear")
    op(OP_CMD, 8'h2C);
    op(OP_CMD, MC_SDC);
    `CHK(1'b1, dc_seen, "addressed clear")
    op(OP_IFC, 8'h00);
    `CHK(2'b00, {talker, listener}, "after ifc")
    ahb(1'b0, 8'h08, 32'h0);
    `CHK(32'h0, r, "unmapped read")
    test_done();
  end
endmodule
